// [logic/aac_pkg.sv]
/*
  Shared constants and state types for the converter control port:
  frame layout, bus addresses, register reset image, timing counts.
  Assumes both ends run from one 100 MHz core clock.
*/
`default_nettype none
package aac_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int SER_MAX_HZ = 5_000_000; // fastest shift clock, Hz
  localparam int I2C_MAX_HZ = 400_000; // fastest scl, Hz
  // least half period of the shift clock, rounded up
  localparam int SER_HALF_CYC = (CLK_HZ + 2 * SER_MAX_HZ - 1) / (2 * SER_MAX_HZ);
  // least quarter period of scl, rounded up
  localparam int I2C_QTR_CYC = (CLK_HZ + 4 * I2C_MAX_HZ - 1) / (4 * I2C_MAX_HZ);

  // ----------------------------------------------------------------
  // three-wire frame
  // ----------------------------------------------------------------
  localparam logic [1:0] CHIP_ADDR = 2'h2;
  localparam logic DIR_WRITE = 1'b1;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int FRM_CHIP_LSB = 14;
  localparam int FRM_DIR_POS = 13;
  localparam int FRM_ADDR_LSB = 8;

  // ----------------------------------------------------------------
  // two-wire bus
  // ----------------------------------------------------------------
  localparam logic [4:0] SLV_ADDR_HI = 5'h04;
  localparam logic SLV_ADDR_LSB = 1'b1;
  localparam logic RW_READ = 1'b1;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  localparam int NUM_REGS = 14;
  localparam logic [4:0] ADDR_TOP = 5'h0D;
  // byte 0 lowest; power control on, both volumes at unity
  localparam logic [NUM_REGS*8-1:0] REG_RESET = 112'h00000000_7F7F_0000_0000_0000_0001;

  // ----------------------------------------------------------------
  // synchroniser bit positions in the device
  // ----------------------------------------------------------------
  localparam int SY_CS = 0;
  localparam int SY_SCK = 1;
  localparam int SY_SDI = 2;
  localparam int SY_SCL = 3;
  localparam int SY_SDA = 4;
  localparam int SY_PDN = 5;
  localparam int SY_STRAP = 6;
  localparam int SY_MODE = 7;
  localparam logic [7:0] SYNC_RST = 8'hFF;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RX = 3'h1,
    D_ACK = 3'h3,
    D_TX = 3'h2,
    D_MACK = 3'h6
  } aac_dst_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_START = 3'h1,
    H_BIT = 3'h3,
    H_STOP = 3'h2,
    H_DONE = 3'h6,
    H_SER = 3'h4
  } aac_hst_t;
endpackage
`default_nettype wire

// [logic/aac_ctrl_if.sv]
/*
  Control link between host and converter: three-wire pins, scl and an
  open-drain sda resolved here with an implied pull-up.
  Assumes the bench connects one host end and one device end.
*/
`timescale 1ns/1ps
`default_nettype none
interface aac_ctrl_if;
  logic serial_chip_select_n;
  logic serial_shift_clock;
  logic serial_data_in;
  logic scl;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;

  // wired-and with pull-up: any enabled low driver wins
  assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

  modport dev (
    input serial_chip_select_n,
    input serial_shift_clock,
    input serial_data_in,
    input scl,
    input sda,
    output sda_d_o,
    output sda_d_oe
  );
  modport host (
    output serial_chip_select_n,
    output serial_shift_clock,
    output serial_data_in,
    output scl,
    output sda_h_o,
    output sda_h_oe,
    input sda
  );
endinterface
`default_nettype wire

// [logic/aac_dev.sv]
/*
  Device end: register write port of the converter, three-wire or
  two-wire bus slave, with the register image as a flat output.
  Assumes link pins are asynchronous to core_clk and are sampled here.
  // Function
  // RULE1: frame is chip 10, write bit, address, data
  // RULE2: sample serial data on shift clock rise
  // RULE3: commit byte when chip select rises
  // RULE4: host keeps shift clock at most 5 MHz
  // RULE5: power-down low restores register defaults
  // RULE6: accept only chip address upper 1, lower 0
  // RULE7: select pin low three-wire, high two-wire
  // RULE8: slave address 00100, strap, then 1
  // RULE9: acknowledge only own address, else stay off
  // RULE10: eighth address bit 1 reads, 0 writes
  // RULE11: host sends register address, top bits zero
  // RULE12: acknowledge every received byte of a write
  // RULE13: commands begin with sda falling, scl high
  // RULE14: stop is sda rising, scl high; ends sequence
  // RULE15: address counter steps after each data byte
  // RULE16: counter wraps from 0DH to 00H
  // RULE17: sda changes only while scl is low
  // RULE18: host clocks acknowledge and releases sda
  // RULE19: slave works up to 400 kHz scl
  // RULE20: three-wire mode has no read path
  // RULE21: host writes 00H..09H, unused bits zero
  // RULE22: drop mismatched three-wire frames without commit
*/
`timescale 1ns/1ps
`default_nettype none
module aac_dev (
  input wire logic core_clk,
  input wire logic rst_b,
  aac_ctrl_if.dev link,
  input wire logic mode_i2c,
  input wire logic bus_address_strap,
  input wire logic power_down_n,
  output logic [aac_pkg::NUM_REGS*8-1:0] reg_file,
  output logic reg_wr_valid,
  output logic [4:0] reg_wr_addr
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] sp;
    aac_pkg::aac_dst_t st;
    logic [15:0] sr;
    logic [4:0] cnt;
    logic [1:0] bidx;
    logic rw;
    logic [4:0] ptr;
    logic mack;
    logic sda_oe;
    logic [aac_pkg::NUM_REGS*8-1:0] regs;
    logic wr_v;
    logic [4:0] wr_a;
  } aac_dev_state_t;

  localparam aac_dev_state_t ST_RST = '{
    s1: aac_pkg::SYNC_RST,
    s2: aac_pkg::SYNC_RST,
    sp: aac_pkg::SYNC_RST,
    st: aac_pkg::D_IDLE,
    regs: aac_pkg::REG_RESET,
    default: '0
  };

  aac_dev_state_t q_r;
  aac_dev_state_t q_nxt;
  logic [7:0] rise;
  logic [7:0] fall;
  logic scl_hi;
  logic sda_in;
  logic [6:0] own_addr;
  logic [7:0] rd_now;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_map(input logic [4:0] a);
    return a <= aac_pkg::ADDR_TOP;
  endfunction

  function automatic logic [4:0] next_ptr(input logic [4:0] a);
    return (a == aac_pkg::ADDR_TOP) ? 5'h00 : 5'(a + 5'h01); // see RULE16
  endfunction

  function automatic logic [7:0] rd_byte(input logic [aac_pkg::NUM_REGS*8-1:0] r,
                                         input logic [4:0] a);
    return in_map(a) ? r[int'(a)*8 +: 8] : 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // edges are taken from the second and third flops only, so the first
  // synchroniser stage never feeds logic
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = {mode_i2c, bus_address_strap, power_down_n, link.sda, link.scl,
                link.serial_data_in, link.serial_shift_clock,
                link.serial_chip_select_n};
    q_nxt.s2 = q_r.s1;
    q_nxt.sp = q_r.s2;
    q_nxt.wr_v = 1'b0;
    rise = q_r.s2 & ~q_r.sp;
    fall = ~q_r.s2 & q_r.sp;
    scl_hi = q_r.s2[aac_pkg::SY_SCL] && q_r.sp[aac_pkg::SY_SCL];
    sda_in = q_r.s2[aac_pkg::SY_SDA];
    own_addr = {aac_pkg::SLV_ADDR_HI, q_r.s2[aac_pkg::SY_STRAP], aac_pkg::SLV_ADDR_LSB};
    // byte at the pointer, loaded whenever a read byte starts
    rd_now = rd_byte(q_r.regs, q_r.ptr);
    if (!q_r.s2[aac_pkg::SY_PDN]) begin
      // held in power-down: defaults back, port idle
      q_nxt.regs = aac_pkg::REG_RESET; // see RULE5
      q_nxt.st = aac_pkg::D_IDLE;
      q_nxt.sda_oe = 1'b0;
      q_nxt.cnt = 5'h00;
      q_nxt.ptr = 5'h00;
    end else if (!q_r.s2[aac_pkg::SY_MODE]) begin // see RULE7
      // three-wire: write only, the two-wire slave stays off the bus
      q_nxt.st = aac_pkg::D_IDLE;
      q_nxt.sda_oe = 1'b0; // see RULE20
      if (q_r.s2[aac_pkg::SY_CS]) begin
        // commit only a whole frame with chip 10 and the write bit
        if (rise[aac_pkg::SY_CS] && q_r.cnt == aac_pkg::FRAME_BITS
            && q_r.sr[15:aac_pkg::FRM_CHIP_LSB] == aac_pkg::CHIP_ADDR // see RULE6
            && q_r.sr[aac_pkg::FRM_DIR_POS] == aac_pkg::DIR_WRITE // see RULE22
            && in_map(q_r.sr[12:aac_pkg::FRM_ADDR_LSB])) begin // see RULE3
          q_nxt.regs[int'(q_r.sr[12:8])*8 +: 8] = q_r.sr[7:0]; // see RULE1
          q_nxt.wr_v = 1'b1;
          q_nxt.wr_a = q_r.sr[12:8];
        end
        q_nxt.cnt = 5'h00;
      end else if (rise[aac_pkg::SY_SCK]) begin
        q_nxt.sr = {q_r.sr[14:0], q_r.s2[aac_pkg::SY_SDI]}; // see RULE2
        // count saturates one past a frame so long frames are dropped
        if (q_r.cnt <= aac_pkg::FRAME_BITS) begin
          q_nxt.cnt = 5'(q_r.cnt + 5'h01);
        end
      end
    end else if (fall[aac_pkg::SY_SDA] && scl_hi) begin
      // start: also a repeated start from any state
      q_nxt.st = aac_pkg::D_RX; // see RULE13
      q_nxt.cnt = 5'h00;
      q_nxt.bidx = 2'h0;
      q_nxt.sda_oe = 1'b0;
    end else if (rise[aac_pkg::SY_SDA] && scl_hi) begin
      q_nxt.st = aac_pkg::D_IDLE; // see RULE14
      q_nxt.sda_oe = 1'b0;
    end else begin
      unique case (q_r.st)
        aac_pkg::D_IDLE: begin
          q_nxt.sda_oe = 1'b0;
        end
        aac_pkg::D_RX: begin
          // data is taken on scl rise, acted on at the eighth fall
          if (rise[aac_pkg::SY_SCL]) begin
            q_nxt.sr[7:0] = {q_r.sr[6:0], sda_in}; // see RULE17
            q_nxt.cnt = 5'(q_r.cnt + 5'h01);
          end else if (fall[aac_pkg::SY_SCL] && q_r.cnt == 5'h08) begin
            q_nxt.cnt = 5'h00;
            q_nxt.st = aac_pkg::D_ACK;
            q_nxt.sda_oe = 1'b1; // see RULE12
            if (q_r.bidx == 2'h0) begin
              q_nxt.rw = q_r.sr[0] == aac_pkg::RW_READ; // see RULE10
              if (q_r.sr[7:1] != own_addr) begin // see RULE8
                q_nxt.st = aac_pkg::D_IDLE; // see RULE9
                q_nxt.sda_oe = 1'b0;
              end
            end else if (q_r.bidx == 2'h1) begin
              q_nxt.ptr = q_r.sr[4:0];
            end else begin
              if (in_map(q_r.ptr)) begin
                q_nxt.regs[int'(q_r.ptr)*8 +: 8] = q_r.sr[7:0];
                q_nxt.wr_v = 1'b1;
                q_nxt.wr_a = q_r.ptr;
              end
              q_nxt.ptr = next_ptr(q_r.ptr); // see RULE15
            end
          end
        end
        aac_pkg::D_ACK: begin
          // hold the acknowledge low across the host's ninth pulse
          if (fall[aac_pkg::SY_SCL]) begin
            q_nxt.sda_oe = 1'b0;
            q_nxt.cnt = 5'h00;
            q_nxt.bidx = (q_r.bidx == 2'h2) ? 2'h2 : 2'(q_r.bidx + 2'h1);
            if (q_r.rw && q_r.bidx == 2'h0) begin
              q_nxt.st = aac_pkg::D_TX;
              q_nxt.sr[7:0] = rd_now;
              q_nxt.sda_oe = ~rd_now[7];
            end else begin
              q_nxt.st = aac_pkg::D_RX;
            end
          end
        end
        aac_pkg::D_TX: begin
          // next bit goes out just after scl falls
          if (fall[aac_pkg::SY_SCL]) begin
            if (q_r.cnt == 5'h07) begin
              q_nxt.sda_oe = 1'b0;
              q_nxt.st = aac_pkg::D_MACK;
              q_nxt.ptr = next_ptr(q_r.ptr);
            end else begin
              q_nxt.sr[7:0] = {q_r.sr[6:0], 1'b0};
              q_nxt.sda_oe = ~q_r.sr[6];
              q_nxt.cnt = 5'(q_r.cnt + 5'h01);
            end
          end
        end
        aac_pkg::D_MACK: begin
          // host acknowledge asks for one more byte, else wait for stop
          if (rise[aac_pkg::SY_SCL]) begin
            q_nxt.mack = ~sda_in;
          end else if (fall[aac_pkg::SY_SCL]) begin
            q_nxt.cnt = 5'h00;
            if (q_r.mack) begin
              q_nxt.st = aac_pkg::D_TX;
              q_nxt.sr[7:0] = rd_now;
              q_nxt.sda_oe = ~rd_now[7];
            end else begin
              q_nxt.st = aac_pkg::D_IDLE;
            end
          end
        end
        default: begin
          q_nxt.st = aac_pkg::D_IDLE;
          q_nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  // 3-cycle sampling lag is far below a 400 kHz quarter period
  always_ff @(posedge core_clk or negedge rst_b) begin // see RULE19
    if (!rst_b) begin
      q_r <= ST_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign link.sda_d_o = 1'b0; // open drain: only ever pulls low
  assign link.sda_d_oe = q_r.sda_oe;
  assign reg_file = q_r.regs;
  assign reg_wr_valid = q_r.wr_v;
  assign reg_wr_addr = q_r.wr_a;
endmodule
`default_nettype wire

// [logic/aac_host.sv]
/*
  Host end: turns one register command into a three-wire frame or a
  two-wire write or read, and reports the answer.
  Assumes command inputs and mode come from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module aac_host (
  input wire logic core_clk,
  input wire logic rst_b,
  aac_ctrl_if.host link,
  input wire logic mode_i2c,
  input wire logic bus_address_strap,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [4:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic s1;
    logic s2;
    aac_pkg::aac_hst_t st;
    logic [6:0] tk;
    logic [1:0] q;
    logic [4:0] bitn;
    logic [1:0] bidx;
    logic seg;
    logic rd;
    logic i2c;
    logic nack;
    logic strap;
    logic [4:0] addr;
    logic [7:0] data;
    logic [7:0] rx;
    logic scl;
    logic sda_oe;
    logic cs_n;
    logic sck;
    logic sdi;
    logic rdy;
    logic rv;
  } aac_host_state_t;

  localparam aac_host_state_t ST_RST = '{
    s1: 1'b1, s2: 1'b1, st: aac_pkg::H_IDLE, scl: 1'b1, cs_n: 1'b1, sck: 1'b1,
    default: '0
  };

  aac_host_state_t q_r;
  aac_host_state_t q_nxt;
  logic tick;
  logic rx_byte;
  logic last_byte;
  logic [7:0] txb;
  logic [15:0] frm;

  // byte on the wire for segment and index; segment 1 is the read phase
  function automatic logic [7:0] tx_byte(input logic seg, input logic [1:0] bi,
                                         input logic [4:0] a, input logic [7:0] d,
                                         input logic strap);
    if (bi == 2'h0) begin
      return {aac_pkg::SLV_ADDR_HI, strap, aac_pkg::SLV_ADDR_LSB,
              seg ? aac_pkg::RW_READ : ~aac_pkg::RW_READ}; // see RULE8
    end else if (bi == 2'h1) begin
      return {3'h0, a}; // see RULE11
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one tick per quarter scl period or per half shift-clock period
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = link.sda;
    q_nxt.s2 = q_r.s1;
    q_nxt.rv = 1'b0;
    tick = q_r.tk == 7'h00;
    rx_byte = q_r.seg && q_r.bidx == 2'h1;
    last_byte = q_r.bidx == ((q_r.rd || q_r.seg) ? 2'h1 : 2'h2);
    txb = tx_byte(q_r.seg, q_r.bidx, q_r.addr, q_r.data, q_r.strap);
    frm = {aac_pkg::CHIP_ADDR, aac_pkg::DIR_WRITE, q_r.addr, q_r.data}; // see RULE1
    if (q_r.st == aac_pkg::H_IDLE) begin
      q_nxt.tk = 7'h00;
    end else if (tick) begin
      q_nxt.tk = q_r.i2c ? 7'(aac_pkg::I2C_QTR_CYC - 1) : 7'(aac_pkg::SER_HALF_CYC - 1);
    end else begin
      q_nxt.tk = 7'(q_r.tk - 7'h01);
    end
    if (tick && q_r.st != aac_pkg::H_SER) begin
      q_nxt.q = 2'(q_r.q + 2'h1);
    end
    unique case (q_r.st)
      aac_pkg::H_IDLE: begin
        q_nxt.rdy = 1'b1;
        if (q_r.rdy && cmd_valid) begin
          q_nxt.rdy = 1'b0;
          q_nxt.rd = cmd_read;
          q_nxt.addr = cmd_addr;
          q_nxt.data = cmd_data;
          q_nxt.i2c = mode_i2c;
          q_nxt.strap = bus_address_strap;
          q_nxt.seg = 1'b0;
          q_nxt.bidx = 2'h0;
          q_nxt.bitn = 5'h00;
          q_nxt.q = 2'h0;
          q_nxt.nack = 1'b0;
          q_nxt.rx = 8'h00;
          if (!mode_i2c && cmd_read) begin
            q_nxt.nack = 1'b1; // see RULE20
            q_nxt.st = aac_pkg::H_DONE;
          end else if (mode_i2c) begin
            q_nxt.st = aac_pkg::H_START;
          end else begin
            q_nxt.st = aac_pkg::H_SER;
            q_nxt.cs_n = 1'b0;
          end
        end
      end
      aac_pkg::H_START: begin
        if (tick) begin
          unique case (q_r.q)
            2'h0: begin
              q_nxt.scl = 1'b1;
              q_nxt.sda_oe = 1'b0;
            end
            2'h1: q_nxt.sda_oe = 1'b1; // see RULE13
            2'h2: q_nxt.scl = 1'b0;
            2'h3: begin
              q_nxt.st = aac_pkg::H_BIT;
              q_nxt.bitn = 5'h00;
            end
          endcase
        end
      end
      aac_pkg::H_BIT: begin
        // sda set a quarter after scl falls, scl high for two quarters
        if (tick) begin
          unique case (q_r.q)
            2'h0: q_nxt.sda_oe = (q_r.bitn < 5'h08 && !rx_byte)
                                 ? ~txb[3'(3'h7 - q_r.bitn[2:0])] : 1'b0; // see RULE18
            2'h1: q_nxt.scl = 1'b1; // see RULE17
            2'h2: q_nxt.scl = 1'b1;
            2'h3: begin
              q_nxt.scl = 1'b0;
              q_nxt.bitn = 5'(q_r.bitn + 5'h01);
              if (q_r.bitn < 5'h08) begin
                q_nxt.rx = {q_r.rx[6:0], q_r.s2};
              end else begin
                q_nxt.bitn = 5'h00;
                if (!rx_byte && q_r.s2) begin
                  q_nxt.nack = 1'b1;
                  q_nxt.st = aac_pkg::H_STOP;
                end else if (last_byte) begin
                  q_nxt.st = aac_pkg::H_STOP;
                end else begin
                  q_nxt.bidx = 2'(q_r.bidx + 2'h1);
                end
              end
            end
          endcase
        end
      end
      aac_pkg::H_STOP: begin
        if (tick) begin
          unique case (q_r.q)
            2'h0: begin
              q_nxt.scl = 1'b0;
              q_nxt.sda_oe = 1'b1;
            end
            2'h1: q_nxt.scl = 1'b1;
            2'h2: q_nxt.sda_oe = 1'b0; // see RULE14
            2'h3: begin
              // a read first sets the pointer, then reads at it
              if (q_r.rd && !q_r.seg && !q_r.nack) begin
                q_nxt.seg = 1'b1;
                q_nxt.bidx = 2'h0;
                q_nxt.st = aac_pkg::H_START;
              end else begin
                q_nxt.st = aac_pkg::H_DONE;
              end
            end
          endcase
        end
      end
      aac_pkg::H_SER: begin
        // half period of 10 cycles keeps the shift clock at 5 MHz
        if (tick) begin // see RULE4
          q_nxt.q = {1'b0, ~q_r.q[0]};
          if (!q_r.q[0]) begin
            q_nxt.sck = 1'b0;
            if (q_r.bitn == aac_pkg::FRAME_BITS) begin
              q_nxt.cs_n = 1'b1;
              q_nxt.st = aac_pkg::H_DONE;
            end else begin
              q_nxt.sdi = frm[4'(4'hF - q_r.bitn[3:0])];
            end
          end else begin
            q_nxt.sck = 1'b1;
            q_nxt.bitn = 5'(q_r.bitn + 5'h01);
          end
        end
      end
      aac_pkg::H_DONE: begin
        if (tick) begin
          q_nxt.rv = 1'b1;
          q_nxt.rdy = 1'b1;
          q_nxt.st = aac_pkg::H_IDLE;
        end
      end
      default: q_nxt.st = aac_pkg::H_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= ST_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign link.serial_chip_select_n = q_r.cs_n;
  assign link.serial_shift_clock = q_r.sck;
  assign link.serial_data_in = q_r.sdi;
  assign link.scl = q_r.scl; // push-pull: the device never stretches
  assign link.sda_h_o = 1'b0;
  assign link.sda_h_oe = q_r.sda_oe;
  assign cmd_ready = q_r.rdy;
  assign rsp_valid = q_r.rv;
  assign rsp_data = q_r.rx;
  assign rsp_nack = q_r.nack;
endmodule
`default_nettype wire

// [tb/aac_link_properties.sv]
/*
  Checker for the control link: watches only the interface pins.
  Assumes host and device ends share core_clk and rst_b.
*/
`timescale 1ns/1ps
`default_nettype none
module aac_link_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic serial_chip_select_n,
  input wire logic serial_shift_clock,
  input wire logic serial_data_in,
  input wire logic scl,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe,
  input wire logic sda
);
  logic sck_q_r;
  logic [4:0] bits_r;
  logic [15:0] shift_r;

  // --------------------------------------------------------------
  // frame tracker
  // --------------------------------------------------------------
  // bit count cleared while deselected, so a short frame fails the length check
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_q_r <= 1'b1;
      bits_r <= 5'h00;
      shift_r <= 16'h0000;
    end else begin
      sck_q_r <= serial_shift_clock;
      if (serial_chip_select_n) begin
        bits_r <= 5'h00;
      end else if (serial_shift_clock && !sck_q_r) begin
        bits_r <= bits_r + 5'h01;
        shift_r <= {shift_r[14:0], serial_data_in};
      end
    end
  end

  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_frame_end; $rose(serial_chip_select_n); endsequence
  sequence s_sda_edge_high; $changed(sda) && scl; endsequence

  property p_frame_len; s_frame_end |-> bits_r == aac_pkg::FRAME_BITS; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame bit count wrong");
  property p_chip_addr;
    s_frame_end |-> shift_r[15:13] == {aac_pkg::CHIP_ADDR, aac_pkg::DIR_WRITE};
  endproperty
  a_chip_addr: assert property (p_chip_addr) else $error("frame header wrong");
  property p_sdi_stable;
    serial_shift_clock && $past(serial_shift_clock) && !serial_chip_select_n
      |-> $stable(serial_data_in);
  endproperty
  a_sdi_stable: assert property (p_sdi_stable) else $error("data moved, clock high");
  property p_modes_apart; !serial_chip_select_n |-> scl; endproperty
  a_modes_apart: assert property (p_modes_apart) else $error("both modes active");
  property p_dev_scl_low; $changed(sda_d_oe) |-> !scl; endproperty
  a_dev_scl_low: assert property (p_dev_scl_low) else $error("device moved sda, scl high");
  property p_host_free; sda_d_oe && scl |-> !sda_h_oe; endproperty
  a_host_free: assert property (p_host_free) else $error("host holds sda at ack");
  property p_start; s_sda_edge_high ##0 !sda |-> sda_h_oe && !sda_d_oe; endproperty
  a_start: assert property (p_start) else $error("start not made by host");
  property p_stop; s_sda_edge_high ##0 sda |-> !sda_d_oe && $past(sda_h_oe); endproperty
  a_stop: assert property (p_stop) else $error("stop not made by host");
endmodule
`default_nettype wire

// [tb/tb_audio_adc_control_port.sv]
/*
  Bench: host end and device end joined by the link interface.
  Assumes a 100 MHz core clock and commands through the host port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_audio_adc_control_port;
  logic core_clk = 1'b0;
  logic rst_b, mode_h, mode_d, strap_h, strap_d, pdn_n, cmd_valid, cmd_read;
  logic cmd_ready, rsp_valid, rsp_nack, wr_v;
  logic [4:0] cmd_addr, wr_a, last_wr_a;
  logic [7:0] cmd_data, rsp_data;
  logic [aac_pkg::NUM_REGS*8-1:0] reg_file;
  int fail_count = 0;
  int total_checks = 0;

  aac_ctrl_if link ();
  aac_dev i_aac_dev (.core_clk(core_clk), .rst_b(rst_b), .link(link.dev),
    .mode_i2c(mode_d), .bus_address_strap(strap_d), .power_down_n(pdn_n),
    .reg_file(reg_file), .reg_wr_valid(wr_v), .reg_wr_addr(wr_a));
  aac_host i_aac_host (.core_clk(core_clk), .rst_b(rst_b), .link(link.host),
    .mode_i2c(mode_h), .bus_address_strap(strap_h), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  aac_link_checker i_aac_link_checker (.core_clk(core_clk), .rst_b(rst_b),
    .serial_chip_select_n(link.serial_chip_select_n),
    .serial_shift_clock(link.serial_shift_clock), .serial_data_in(link.serial_data_in),
    .scl(link.scl), .sda_h_oe(link.sda_h_oe), .sda_d_oe(link.sda_d_oe), .sda(link.sda));

  // --------------------------------------------------------------
  // clock, watchdog, tasks
  // --------------------------------------------------------------
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // tests need about 21k cycles; the two-wire commands dominate
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    complete_run();
  end

  // last committed address, held for the write checks
  always @(posedge core_clk) begin
    if (wr_v) last_wr_a <= wr_a;
  end

  function automatic logic [7:0] rg(input int a);
    return reg_file[a*8 +: 8];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one command, held until taken; values read at edges are pre-edge flop outputs
  task automatic cmd(input logic rd, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    while (cmd_ready !== 1'b1) @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1) @(posedge core_clk);
    repeat (8) @(posedge core_clk);
  endtask

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    {rst_b, mode_h, mode_d, cmd_valid, cmd_read} = 5'h00;
    {strap_h, strap_d, pdn_n} = 3'h7;
    cmd_addr = 5'h00;
    cmd_data = 8'h00;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < aac_pkg::NUM_REGS; i++) begin
      check(rg(i), aac_pkg::REG_RESET[i*8 +: 8]);
    end
    $display("test reset done");
    cmd(1'b0, 5'h03, 8'hA5);
    check(rg(3), 8'hA5);
    check({3'h0, last_wr_a}, 8'h03);
    cmd(1'b1, 5'h03, 8'h00);
    check({7'h00, rsp_nack}, 8'h01);
    mode_d <= 1'b1;
    cmd(1'b0, 5'h04, 8'h3C);
    check(rg(4), 8'h00);
    $display("test three_wire done");
    mode_h <= 1'b1;
    cmd(1'b0, 5'h09, 8'h5A);
    check({7'h00, rsp_nack}, 8'h00);
    check({3'h0, last_wr_a}, 8'h09);
    check(rg(9), 8'h5A);
    cmd(1'b1, 5'h09, 8'h00);
    check(rsp_data, 8'h5A);
    strap_h <= 1'b0;
    cmd(1'b0, 5'h01, 8'h07);
    check({7'h00, rsp_nack}, 8'h01);
    check(rg(1), 8'h00);
    check({3'h0, last_wr_a}, 8'h09);
    $display("test two_wire done");
    pdn_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    pdn_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    check(rg(9), 8'h7F);
    check(rg(3), 8'h00);
    $display("test power_down done");
    complete_run();
  end
endmodule
`default_nettype wire
